/* File: design/ctcr_regs.sv */
// charger thermal, interrupt-mask and charge-current register bank
`timescale 1ns/1ps
`include "ctcr_defines.svh"
module ctcr_regs
  import ctcr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire ctcr_req_t req_i,
  input wire logic [1:0] thermistor_zone_i,
  input wire logic thermistor_open_i,
  input wire logic fuse_open_thermistor_stop_i,
  input wire logic charge_resistor_pin_grounded_i,
  input wire logic pushbutton_wake_i,
  input wire logic pushbutton_reset_i,
  input wire logic safety_timer_fault_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic thermistor_enable_o,
  output logic irq_with_status_o,
  output logic pushbutton_wake_o,
  output logic pushbutton_reset_o,
  output logic safety_timer_fault_o,
  output logic thermistor_stop_o,
  output logic charge_half_o,
  output logic voltage_lowered_o,
  output ctcr_charge_t charge_o,
  output logic [1:0] current_source_o,
  output logic [4:0] termination_current_code_o,
  output logic termination_range_o,
  output logic charge_cutoff_allow_o
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  wire [`CTCR_SYNC_W-1:0] async_in = {thermistor_zone_i, thermistor_open_i,
                                      charge_resistor_pin_grounded_i, pushbutton_wake_i,
                                      pushbutton_reset_i, safety_timer_fault_i};
  wire [`CTCR_SYNC_W-1:0] sync_s;

  // two flops per pin; only the second stage is read by the logic
  genvar sync_idx;
  generate
    for (sync_idx = 0; sync_idx < `CTCR_SYNC_W; sync_idx = sync_idx + 1) begin : g_sync
      logic stage1_r;
      logic stage2_r;
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stage1_r <= 1'b0;
          stage2_r <= 1'b0;
        end else begin
          stage1_r <= async_in[sync_idx];
          stage2_r <= stage1_r;
        end
      end
      assign sync_s[sync_idx] = stage2_r;
    end
  endgenerate

  wire [1:0] zone_s;
  wire open_s;
  wire pin_gnd_s;
  wire wake_s;
  wire rstev_s;
  wire timer_s;
  assign {zone_s, open_s, pin_gnd_s, wake_s, rstev_s, timer_s} = sync_s;

  // ************************************************************
  // decode functions
  // ************************************************************
  // true when the reported zone equals the one asked for
  function automatic logic zone_is(input logic [1:0] zone, input logic [1:0] want);
    return zone == want;
  endfunction : zone_is

  // limits a current code to the largest legal code of its range
  function automatic logic [4:0] clamp_code(input logic [4:0] raw, input logic [4:0] limit);
    return (raw > limit) ? limit : raw;
  endfunction : clamp_code

  // ************************************************************
  // registers
  // ************************************************************
  logic therm_en_r;
  logic [3:0] therm_ctrl_r;
  logic [7:0] fast_r;
  logic [7:0] term_r;
  logic [2:0] therm_stat_r;

  wire wr_therm = req_i.wr && (req_i.addr == `CTCR_OFS_THERM);
  wire wr_fast = req_i.wr && (req_i.addr == `CTCR_OFS_FAST);
  wire wr_term = req_i.wr && (req_i.addr == `CTCR_OFS_TERM);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      therm_en_r <= `CTCR_RST_THERM_EN;
      therm_ctrl_r <= `CTCR_RST_THERM_CTRL;
      fast_r <= `CTCR_RST_FAST;
      term_r <= `CTCR_RST_TERM;
    end else begin
      if (wr_therm) begin
        // status bits 6:4 are not written
        therm_en_r <= req_i.wdata[`CTCR_BIT_EN];
        therm_ctrl_r <= req_i.wdata[`CTCR_BIT_CONTENT:`CTCR_BIT_TIMER_M];
      end
      if (wr_fast) begin
        fast_r <= req_i.wdata;
      end
      if (wr_term) begin
        term_r <= req_i.wdata;
      end
    end
  end

  // ************************************************************
  // thermistor status
  // ************************************************************
  // monitoring disabled shows a normal zone and no open fault
  wire [1:0] zone_nxt = therm_en_r ? zone_s : `CTCR_ZONE_NORMAL;
  wire open_nxt = therm_en_r & open_s;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      therm_stat_r <= 3'h0;
    end else begin
      therm_stat_r <= {zone_nxt, open_nxt};
    end
  end

  wire [1:0] stat_zone;
  wire stat_open;
  assign {stat_zone, stat_open} = therm_stat_r;

  // ************************************************************
  // charge current decode
  // ************************************************************
  wire range_hi = fast_r[`CTCR_BIT_RANGE];
  wire [4:0] code = fast_r[`CTCR_CODE_HI:`CTCR_CODE_LO];
  wire code_ext = (code == `CTCR_CODE_ALL_ONES);
  wire [4:0] lo_code = clamp_code(code, `CTCR_LO_MAX_CODE);
  wire [4:0] hi_code = clamp_code(code, `CTCR_HI_MAX_CODE);
  wire [8:0] lo_ma = `CTCR_LO_BASE_MA + {4'h0, lo_code};
  wire [8:0] hi_mul = 9'(hi_code * `CTCR_HI_STEP_MA);
  wire [8:0] hi_ma = `CTCR_HI_BASE_MA + hi_mul;
  // all-ones code: external resistor unless its pin is grounded, then fuse default; other codes: register
  wire [1:0] src_nxt = !code_ext ? CTCR_SRC_REG :
                       (pin_gnd_s ? CTCR_SRC_FUSE : CTCR_SRC_RESISTOR);

  ctcr_charge_t charge_nxt;
  assign charge_nxt.use_external = code_ext;
  assign charge_nxt.current_ma = code_ext ? 9'h000 : (range_hi ? hi_ma : lo_ma);
  assign charge_nxt.charger_disable = fast_r[`CTCR_BIT_DISABLE];
  assign charge_nxt.high_impedance = fast_r[`CTCR_BIT_HIZ];

  // ************************************************************
  // read mux
  // ************************************************************
  wire [7:0] therm_rd = {therm_en_r, therm_stat_r, therm_ctrl_r};
  wire [7:0] rdata_nxt = (req_i.addr == `CTCR_OFS_THERM) ? therm_rd :
                         (req_i.addr == `CTCR_OFS_FAST) ? fast_r :
                         (req_i.addr == `CTCR_OFS_TERM) ? term_r : `CTCR_UNMAPPED_READ;

  // ************************************************************
  // output next values
  // ************************************************************
  wire wake_nxt = wake_s & ~therm_ctrl_r[`CTCR_BIT_WAKE_M];
  wire rstev_nxt = rstev_s & ~therm_ctrl_r[`CTCR_BIT_RESET_M];
  wire timer_nxt = timer_s & ~therm_ctrl_r[`CTCR_BIT_TIMER_M];
  // an open thermistor stops charging only when the fuse option allows it
  wire stop_nxt = (stat_open & fuse_open_thermistor_stop_i) |
                  zone_is(stat_zone, `CTCR_ZONE_SUSPEND);
  wire half_nxt = zone_is(stat_zone, `CTCR_ZONE_COOL);
  wire lowered_nxt = zone_is(stat_zone, `CTCR_ZONE_WARM);
  wire [4:0] term_code_nxt = term_r[`CTCR_CODE_HI:`CTCR_CODE_LO];

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
    end
  end

  // read data holds until the next read
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (req_i.rd) begin
      rdata_o <= rdata_nxt;
    end
  end

  // ************************************************************
  // thermistor control and event masks
  // ************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thermistor_enable_o <= `CTCR_RST_THERM_EN;
    end else begin
      thermistor_enable_o <= therm_en_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_with_status_o <= `CTCR_RST_IRQ_CONTENT;
    end else begin
      irq_with_status_o <= therm_ctrl_r[`CTCR_BIT_CONTENT];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pushbutton_wake_o <= 1'b0;
    end else begin
      pushbutton_wake_o <= wake_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pushbutton_reset_o <= 1'b0;
    end else begin
      pushbutton_reset_o <= rstev_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      safety_timer_fault_o <= 1'b0;
    end else begin
      safety_timer_fault_o <= timer_nxt;
    end
  end

  // ************************************************************
  // thermistor zone actions
  // ************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thermistor_stop_o <= 1'b0;
    end else begin
      thermistor_stop_o <= stop_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      charge_half_o <= 1'b0;
    end else begin
      charge_half_o <= half_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      voltage_lowered_o <= 1'b0;
    end else begin
      voltage_lowered_o <= lowered_nxt;
    end
  end

  // ************************************************************
  // charge settings
  // ************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      charge_o <= '0;
    end else begin
      charge_o <= charge_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      current_source_o <= CTCR_SRC_REG;
    end else begin
      current_source_o <= src_nxt;
    end
  end

  // ************************************************************
  // termination settings
  // ************************************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      termination_current_code_o <= '0;
    end else begin
      termination_current_code_o <= term_code_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      termination_range_o <= 1'b0;
    end else begin
      termination_range_o <= term_r[`CTCR_BIT_TERM_RANGE];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      charge_cutoff_allow_o <= 1'b0;
    end else begin
      charge_cutoff_allow_o <= term_r[`CTCR_BIT_CUTOFF];
    end
  end

endmodule : ctcr_regs

/* File: design/ctcr_defines.svh */
// register offsets, field positions and reset values for the charger control bank
`ifndef CTCR_DEFINES_SVH
`define CTCR_DEFINES_SVH
`define CTCR_OFS_THERM 8'h02
`define CTCR_OFS_FAST 8'h03
`define CTCR_OFS_TERM 8'h04
`define CTCR_UNMAPPED_READ 8'hFF
`define CTCR_RST_THERM_CTRL 4'h8
`define CTCR_RST_THERM_EN 1'h1
`define CTCR_RST_FAST 8'h14
`define CTCR_RST_TERM 8'h0E
`define CTCR_CODE_ALL_ONES 5'h1F
`define CTCR_LO_MAX_CODE 5'h1E
`define CTCR_HI_MAX_CODE 5'h1A
`define CTCR_LO_BASE_MA 9'h005
`define CTCR_HI_BASE_MA 9'h028
`define CTCR_HI_STEP_MA 9'h00A
`define CTCR_ZONE_NORMAL 2'h0
`define CTCR_ZONE_SUSPEND 2'h1
`define CTCR_ZONE_COOL 2'h2
`define CTCR_ZONE_WARM 2'h3
`define CTCR_BIT_EN 7
`define CTCR_BIT_CONTENT 3
`define CTCR_BIT_WAKE_M 2
`define CTCR_BIT_RESET_M 1
`define CTCR_BIT_TIMER_M 0
`define CTCR_BIT_RANGE 7
`define CTCR_BIT_DISABLE 1
`define CTCR_BIT_HIZ 0
`define CTCR_BIT_CUTOFF 1
`define CTCR_BIT_TERM_RANGE 7
`define CTCR_CODE_HI 6
`define CTCR_CODE_LO 2
`define CTCR_SYNC_W 7
`define CTCR_RST_IRQ_CONTENT 1'h1
`endif

/* File: design/ctcr_pkg.sv */
// types shared by the charger control bank
package ctcr_pkg;
  // register access request from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctcr_req_t;
  // decoded charge settings
  typedef struct packed {
    logic use_external;
    logic [8:0] current_ma;
    logic charger_disable;
    logic high_impedance;
  } ctcr_charge_t;
  typedef enum logic [1:0] {
    CTCR_SRC_REG,
    CTCR_SRC_RESISTOR,
    CTCR_SRC_FUSE
  } ctcr_src_t;
endpackage : ctcr_pkg

/* File: sim/ctcr_regs_properties.sv */
// assertions on the charger control bank ports
`timescale 1ns/1ps
module ctcr_regs_chk
  import ctcr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire ctcr_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic thermistor_enable_o,
  input wire logic irq_with_status_o,
  input wire logic pushbutton_wake_o,
  input wire logic pushbutton_reset_o,
  input wire logic safety_timer_fault_o,
  input wire logic charge_half_o,
  input wire logic voltage_lowered_o,
  input wire ctcr_charge_t charge_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire w2 = req_i.wr && req_i.addr == 8'h02;
  wire w3 = req_i.wr && req_i.addr == 8'h03;
  wire unm = req_i.rd && (req_i.addr < 8'h02 || req_i.addr > 8'h04);
  sequence s_w2; w2 ##1 !w2; endsequence
  sequence s_w3; w3 ##1 !w3; endsequence
  property p_rv; req_i.rd |=> rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_unm; unm |=> rdata_o == 8'hFF; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read wrong");
  property p_en; s_w2 |=> thermistor_enable_o == $past(req_i.wdata[7], 2); endproperty
  a_en: assert property (p_en) else $error("enable bit wrong");
  property p_irq; s_w2 |=> irq_with_status_o == $past(req_i.wdata[3], 2); endproperty
  a_irq: assert property (p_irq) else $error("content bit wrong");
  property p_wk; (w2 && req_i.wdata[2]) ##1 !w2 |=> !pushbutton_wake_o; endproperty
  a_wk: assert property (p_wk) else $error("wake not masked");
  property p_rs; (w2 && req_i.wdata[1]) ##1 !w2 |=> !pushbutton_reset_o; endproperty
  a_rs: assert property (p_rs) else $error("reset not masked");
  property p_tm; (w2 && req_i.wdata[0]) ##1 !w2 |=> !safety_timer_fault_o; endproperty
  a_tm: assert property (p_tm) else $error("timer not masked");
  property p_dis;
    s_w3 |=> {charge_o.charger_disable, charge_o.high_impedance} == $past(req_i.wdata[1:0], 2);
  endproperty
  a_dis: assert property (p_dis) else $error("disable or hiz wrong");
  property p_ext;
    s_w3 |=> charge_o.use_external == ($past(req_i.wdata[6:2], 2) == 5'h1F);
  endproperty
  a_ext: assert property (p_ext) else $error("external select wrong");
  property p_sat; charge_o.current_ma <= 9'h12C; endproperty
  a_sat: assert property (p_sat) else $error("current above limit");
  property p_zn; !(charge_half_o && voltage_lowered_o); endproperty
  a_zn: assert property (p_zn) else $error("two zones at once");
endmodule : ctcr_regs_chk
bind ctcr_regs ctcr_regs_chk u_chk (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .req_i(req_i),
  .rdata_o(rdata_o),
  .rvalid_o(rvalid_o),
  .thermistor_enable_o(thermistor_enable_o),
  .irq_with_status_o(irq_with_status_o),
  .pushbutton_wake_o(pushbutton_wake_o),
  .pushbutton_reset_o(pushbutton_reset_o),
  .safety_timer_fault_o(safety_timer_fault_o),
  .charge_half_o(charge_half_o),
  .voltage_lowered_o(voltage_lowered_o),
  .charge_o(charge_o)
);

/* File: sim/ctcr_host_model.sv */
// host model issuing register requests
`timescale 1ns/1ps
module ctcr_host_model
  import ctcr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output ctcr_req_t req_o
);
  initial req_o = '0;
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge mclk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk_i);
    // released fields carry junk
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = 8'h00;
    // read answer stands for the cycle after the request; sample it mid-cycle
    if (!w) begin
      @(negedge mclk_i);
      q = rvalid_i ? rdata_i : 8'hXX;
      @(posedge mclk_i);
    end
  endtask : acc
endmodule : ctcr_host_model

/* File: sim/charger_thermal_current_regs_test.sv */
// self-checking bench for the charger control register bank
`timescale 1ns/1ps
module charger_thermal_current_regs_test
  import ctcr_pkg::*;
;
  logic mclk_i = 0, rst_n_i = 0, thermistor_open_i = 0, fuse_open_thermistor_stop_i = 0;
  logic charge_resistor_pin_grounded_i = 0, pushbutton_wake_i = 0, pushbutton_reset_i = 0;
  logic safety_timer_fault_i = 0, rvalid_o, thermistor_enable_o, irq_with_status_o;
  logic pushbutton_wake_o, pushbutton_reset_o, safety_timer_fault_o, thermistor_stop_o;
  logic charge_half_o, voltage_lowered_o, termination_range_o, charge_cutoff_allow_o;
  logic [1:0] thermistor_zone_i = 0, current_source_o;
  logic [4:0] termination_current_code_o;
  logic [7:0] rdata_o, q;
  ctcr_req_t req_i;
  ctcr_charge_t charge_o;
  wire [2:0] events_seen = {pushbutton_wake_o, pushbutton_reset_o, safety_timer_fault_o};
  wire [2:0] zones_seen = {thermistor_stop_o, charge_half_o, voltage_lowered_o};
  wire [6:0] term_seen = {termination_range_o, termination_current_code_o,
                          charge_cutoff_allow_o};
  wire [1:0] dh_seen = {charge_o.charger_disable, charge_o.high_impedance};
  int failures = 0, total_checks = 0;
  logic [7:0] cw [7] = '{8'h00, 8'h78, 8'h7C, 8'h80, 8'hE8, 8'hEC, 8'h17};
  logic [8:0] em [7] = '{9'h005, 9'h023, 9'h000, 9'h028, 9'h12C, 9'h12C, 9'h00A};
  always #50 mclk_i = ~mclk_i;
  ctcr_regs uut (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .thermistor_zone_i(thermistor_zone_i),
    .thermistor_open_i(thermistor_open_i),
    .fuse_open_thermistor_stop_i(fuse_open_thermistor_stop_i),
    .charge_resistor_pin_grounded_i(charge_resistor_pin_grounded_i),
    .pushbutton_wake_i(pushbutton_wake_i),
    .pushbutton_reset_i(pushbutton_reset_i),
    .safety_timer_fault_i(safety_timer_fault_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .thermistor_enable_o(thermistor_enable_o),
    .irq_with_status_o(irq_with_status_o),
    .pushbutton_wake_o(pushbutton_wake_o),
    .pushbutton_reset_o(pushbutton_reset_o),
    .safety_timer_fault_o(safety_timer_fault_o),
    .thermistor_stop_o(thermistor_stop_o),
    .charge_half_o(charge_half_o),
    .voltage_lowered_o(voltage_lowered_o),
    .charge_o(charge_o),
    .current_source_o(current_source_o),
    .termination_current_code_o(termination_current_code_o),
    .termination_range_o(termination_range_o),
    .charge_cutoff_allow_o(charge_cutoff_allow_o)
  );
  ctcr_host_model h (.mclk_i(mclk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o), .req_o(req_i));
  task chk(input string n, input logic [8:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rd(input logic [7:0] a, e);
    h.acc(1'b0, a, 8'h00, q);
    chk("rdata", {1'b0, e}, {1'b0, q});
  endtask : rd
  task wr(input logic [7:0] a, d);
    h.acc(1'b1, a, d, q);
  endtask : wr
  task wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
  initial begin
    wt(10);
    rst_n_i <= 1;
    rd(8'h02, 8'h88);
    rd(8'h03, 8'h14);
    rd(8'h04, 8'h0E);
    rd(8'h05, 8'hFF);
    chk("ma", 9'h00A, charge_o.current_ma);
    $display("reset test done");
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h8F);
    {pushbutton_wake_i, pushbutton_reset_i, safety_timer_fault_i} <= 3'h7;
    wt(5);
    chk("masked", 9'h000, events_seen);
    chk("en", 9'h003, {thermistor_enable_o, irq_with_status_o});
    wr(8'h02, 8'h00);
    wt(2);
    chk("open", 9'h007, events_seen);
    chk("en", 9'h000, {thermistor_enable_o, irq_with_status_o});
    $display("mask test done");
    wr(8'h04, 8'h06);
    rd(8'h04, 8'h06);
    chk("term", 9'h003, term_seen);
    for (int i = 0; i < 7; i++) begin
      wr(8'h03, cw[i]);
      wt(2);
      chk("ma", em[i], charge_o.current_ma);
      chk("ext", {8'h00, cw[i][6:2] == 5'h1F}, charge_o.use_external);
      chk("src", {8'h00, cw[i][6:2] == 5'h1F}, current_source_o);
      chk("dh", {7'h00, cw[i][1:0]}, dh_seen);
    end
    wr(8'h03, 8'h7C);
    wt(2);
    chk("src", 9'h001, current_source_o);
    charge_resistor_pin_grounded_i <= 1;
    wt(5);
    chk("src", 9'h002, current_source_o);
    $display("current test done");
    wr(8'h02, 8'h80);
    for (int z = 0; z < 4; z++) begin
      thermistor_zone_i <= z[1:0];
      wt(5);
      chk("zone", {6'h00, z == 1, z == 2, z == 3}, zones_seen);
      rd(8'h02, {1'b1, z[1:0], 5'h00});
    end
    thermistor_zone_i <= 0;
    thermistor_open_i <= 1;
    fuse_open_thermistor_stop_i <= 1;
    wt(5);
    chk("stop", 9'h001, thermistor_stop_o);
    rd(8'h02, 8'h90);
    fuse_open_thermistor_stop_i <= 0;
    wt(2);
    chk("stop", 9'h000, thermistor_stop_o);
    thermistor_zone_i <= 2'h2;
    wr(8'h02, 8'h00);
    wt(5);
    chk("zone", 9'h000, zones_seen);
    rd(8'h02, 8'h00);
    $display("thermistor test done");
    thermistor_zone_i <= 2'h0;
    thermistor_open_i <= 1'b0;
    wr(8'h03, 8'h83);
    rst_n_i <= 0;
    wt(3);
    chk("rst", 9'h003, {thermistor_enable_o, irq_with_status_o});
    chk("rst", 9'h000, charge_o.current_ma);
    rst_n_i <= 1;
    rd(8'h03, 8'h14);
    rd(8'h02, 8'h88);
    rd(8'h04, 8'h0E);
    chk("ma", 9'h00A, charge_o.current_ma);
    $display("second reset test done");
    give_verdict();
  end
endmodule : charger_thermal_current_regs_test
